/* logic/output_scaler_regs.vh */
// Register map, field layouts, reset values and encodings of the analog output scaler.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef OUTPUT_SCALER_REGS_VH
`define OUTPUT_SCALER_REGS_VH

// ----------------------------------------------------------------
// Per-channel register offsets and stride, plus global status offset (byte addresses)
// ----------------------------------------------------------------
`define CH_STRIDE 12'h020
`define OFS_DEMAND 12'h000
`define OFS_SCALE 12'h004
`define OFS_OFFSET 12'h008
`define OFS_CTRL 12'h00c
`define OFS_CODE 12'h010
`define OFS_STATUS 12'h100

// ----------------------------------------------------------------
// Fields and values (percent in hundredths)
// ----------------------------------------------------------------
`define PCT_W 17
`define PCT_LIMIT 17'sh0753_0
`define PCT_FULL 17'sh0271_0
`define PCT_ZERO 17'sh0000_0
`define CTRL_MAG_BIT 2
`define CTRL_RANGE_MSB 1
`define RANGE_BIPOLAR_V 2'h0
`define RANGE_UNI_V 2'h1
`define RANGE_0_20MA 2'h2
`define RANGE_4_20MA 2'h3
`define CODE_W 16
`define CODE_ZERO 16'h0000
`define CODE_MID 16'h8000
`define CODE_FULL 16'hffff
`define CODE_4MA 16'h3333
`define DEFAULT_SCALE 17'sh0271_0
`define DEFAULT_DEMAND 17'sh0000_0
`define DEFAULT_DEMAND_CH2 17'sh0271_0
`define TICK_NS 1000000
`define CLK_NS 4

`endif

/* logic/scaler_channel.v */
// One analog output channel: scale, offset, magnitude, clamp and range mapping.
// Assumes demand/scale/offset already within plus or minus 300 percent.
`timescale 1ns/1ns
`include "output_scaler_regs.vh"

module scaler_channel #(
	parameter BIPOLAR_OK = 0
) (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire tick_in,
	input wire signed [`PCT_W-1:0] demand_in,
	input wire signed [`PCT_W-1:0] scale_in,
	input wire signed [`PCT_W-1:0] offset_in,
	input wire magnitude_select_in,
	input wire [1:0] range_in,
	output reg [`CODE_W-1:0] code_out,
	output reg illegal_out,
	output reg signed [`PCT_W-1:0] final_out
);
	reg signed [33:0] prod;
	reg signed [33:0] scaled;
	reg signed [33:0] summed;
	reg signed [`PCT_W-1:0] clamped;
	reg signed [`PCT_W-1:0] lim;
	reg [33:0] ucode;
	reg [`CODE_W-1:0] code_d;
	reg illegal;

	always @*
	begin
		prod = demand_in * scale_in;
		scaled = prod / 34'sd10000;
		summed = scaled + offset_in;
		if (summed > `PCT_FULL)
			clamped = `PCT_FULL;
		else if (summed < -`PCT_FULL)
			clamped = -`PCT_FULL;
		else
			clamped = summed[`PCT_W-1:0];
		if (magnitude_select_in && clamped < 0)
			lim = -clamped;
		else
			lim = clamped;
		// Unipolar ranges cannot show a negative demand
		if (range_in != `RANGE_BIPOLAR_V && lim < 0)
			lim = `PCT_ZERO;
		illegal = (range_in == `RANGE_BIPOLAR_V) && (BIPOLAR_OK == 0);
		ucode = 34'd0;
		case (range_in)
		`RANGE_BIPOLAR_V:
			ucode = (lim + `PCT_FULL) * 34'sd65535 / (2 * `PCT_FULL);
		`RANGE_4_20MA:
			ucode = `CODE_4MA + lim * (`CODE_FULL - `CODE_4MA) / `PCT_FULL;
		default:
			ucode = lim * 34'sd65535 / `PCT_FULL;
		endcase
		// Illegal range only arises on unipolar hardware, where code zero is 0 V
		code_d = illegal ? `CODE_ZERO : ucode[`CODE_W-1:0];
	end

	always @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			code_out <= `CODE_ZERO;
			illegal_out <= 1'b0;
			final_out <= `PCT_ZERO;
		end
		else if (tick_in)
		begin
			code_out <= code_d;
			illegal_out <= illegal;
			final_out <= lim;
		end
	end
endmodule // scaler_channel

/* logic/analog_output_scaler.v */
// Analog output scaler top: APB register file, 1 ms tick and up to three channels.
// Assumes a synchronous APB master on core_clk_in (250 MHz).
// Functional notes
// - Scale 100.00 percent is unity gain
// - Offset added after scaling; zero has none
// - Clamp result to plus/minus 100 percent
// - Magnitude select drives absolute value
// - Otherwise limit to selected range span
// - Range codes: bipolar V, 0-10V, 0-20mA, 4-20mA
// - Unsupported range holds output at zero volts
// - Channels one, two unipolar; three also bipolar
// - Plus 100 percent full scale, minus -10V
// - Two or three channels by variant
// - Channel two demand resets to 100 percent
// - Recompute all channels each 1 ms tick
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "output_scaler_regs.vh"

module analog_output_scaler #(
	parameter NUM_CHANNELS = 3,
	parameter TICK_CYCLES = `TICK_NS / `CLK_NS
) (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	output reg [`CODE_W-1:0] first_output_channel_out,
	output reg [`CODE_W-1:0] second_output_channel_out,
	output reg [`CODE_W-1:0] third_output_channel_out,
	output reg tick_out
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg signed [`PCT_W-1:0] demand_q [0:2];
	reg signed [`PCT_W-1:0] scale_q [0:2];
	reg signed [`PCT_W-1:0] offset_q [0:2];
	reg [2:0] ctrl_q [0:2];
	reg signed [`PCT_W-1:0] demand_l_q [0:2];
	reg signed [`PCT_W-1:0] scale_l_q [0:2];
	reg signed [`PCT_W-1:0] offset_l_q [0:2];
	reg [2:0] ctrl_l_q [0:2];
	reg [31:0] tick_cnt_q;
	reg latch_q;
	reg out_strobe_q;
	wire [`CODE_W-1:0] code [0:2];
	wire [2:0] illegal;
	wire [1:0] ch_sel;
	wire [7:0] reg_ofs;
	wire ch_ok;
	wire st_sel;
	wire access;
	reg [31:0] rdata;
	reg hit;
	integer i;

	assign ch_sel = paddr_in[6:5];
	assign reg_ofs = {3'h0, paddr_in[4:0]};
	assign ch_ok = (paddr_in[11:7] == 5'h00) && (ch_sel < NUM_CHANNELS);
	assign st_sel = (paddr_in == `OFS_STATUS);
	assign access = psel_in && penable_in && !pready_out;

	// Saturate a written word to plus/minus 300.00 percent
	function signed [`PCT_W-1:0] sat;
		input [31:0] w;
		reg signed [31:0] s;
		begin
			s = w;
			if (s > `PCT_LIMIT)
				sat = `PCT_LIMIT;
			else if (s < -`PCT_LIMIT)
				sat = -`PCT_LIMIT;
			else
				sat = s[`PCT_W-1:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always @*
	begin
		rdata = 32'h0000_0000;
		hit = 1'b1;
		if (st_sel)
			rdata = {29'h0, illegal};
		else if (ch_ok)
		begin
			case (reg_ofs)
			`OFS_DEMAND:
				rdata = {{15{demand_q[ch_sel][`PCT_W-1]}}, demand_q[ch_sel]};
			`OFS_SCALE:
				rdata = {{15{scale_q[ch_sel][`PCT_W-1]}}, scale_q[ch_sel]};
			`OFS_OFFSET:
				rdata = {{15{offset_q[ch_sel][`PCT_W-1]}}, offset_q[ch_sel]};
			`OFS_CTRL:
				rdata = {29'h0, ctrl_q[ch_sel]};
			`OFS_CODE:
				rdata = {16'h0000, code[ch_sel]};
			default:
				hit = 1'b0;
			endcase
		end
		else
			hit = 1'b0;
	end

	// ----------------------------------------------------------------
	// APB slave: one wait state, answer on second access cycle
	// ----------------------------------------------------------------
	always @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			for (i = 0; i < 3; i = i + 1)
			begin
				demand_q[i] <= (i == 1) ? `DEFAULT_DEMAND_CH2 : `DEFAULT_DEMAND;
				scale_q[i] <= `DEFAULT_SCALE;
				offset_q[i] <= `PCT_ZERO;
				ctrl_q[i] <= (i == 2) ? {1'b0, `RANGE_BIPOLAR_V} : {1'b0, `RANGE_UNI_V};
			end
		end
		else
		begin
			pready_out <= access;
			pslverr_out <= access && !hit;
			prdata_out <= (access && !pwrite_in && hit) ? rdata : 32'h0000_0000;
			// Write lands on the edge where the master sees ready, not one earlier
			if (psel_in && penable_in && pready_out && pwrite_in && hit && ch_ok)
			begin
				case (reg_ofs)
				`OFS_DEMAND:
					demand_q[ch_sel] <= sat(pwdata_in);
				`OFS_SCALE:
					scale_q[ch_sel] <= sat(pwdata_in);
				`OFS_OFFSET:
					offset_q[ch_sel] <= sat(pwdata_in);
				`OFS_CTRL:
					ctrl_q[ch_sel] <= pwdata_in[`CTRL_MAG_BIT:0];
				default:
					ctrl_q[ch_sel] <= ctrl_q[ch_sel];
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// 1 ms period: latch inputs at start, compute next cycle
	// ----------------------------------------------------------------
	always @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			tick_cnt_q <= 32'h0000_0000;
			latch_q <= 1'b0;
			for (i = 0; i < 3; i = i + 1)
			begin
				demand_l_q[i] <= `PCT_ZERO;
				scale_l_q[i] <= `PCT_ZERO;
				offset_l_q[i] <= `PCT_ZERO;
				ctrl_l_q[i] <= {1'b0, `RANGE_UNI_V};
			end
		end
		else
		begin
			latch_q <= (tick_cnt_q == TICK_CYCLES - 1);
			if (tick_cnt_q == TICK_CYCLES - 1)
			begin
				tick_cnt_q <= 32'h0000_0000;
				for (i = 0; i < 3; i = i + 1)
				begin
					demand_l_q[i] <= demand_q[i];
					scale_l_q[i] <= scale_q[i];
					offset_l_q[i] <= offset_q[i];
					ctrl_l_q[i] <= ctrl_q[i];
				end
			end
			else
				tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : ch
			if (g < NUM_CHANNELS)
			begin : used
				scaler_channel #(
					.BIPOLAR_OK(g == 2 ? 1 : 0)
				) u_ch (
					.core_clk_in(core_clk_in),
					.rst_b_in(rst_b_in),
					.tick_in(latch_q),
					.demand_in(demand_l_q[g]),
					.scale_in(scale_l_q[g]),
					.offset_in(offset_l_q[g]),
					.magnitude_select_in(ctrl_l_q[g][`CTRL_MAG_BIT]),
					.range_in(ctrl_l_q[g][`CTRL_RANGE_MSB:0]),
					.code_out(code[g]),
					.illegal_out(illegal[g]),
					.final_out()
				);
			end
			else
			begin : unused
				assign code[g] = `CODE_ZERO;
				assign illegal[g] = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Update strobe
	// ----------------------------------------------------------------
	// Tick is delayed twice: channel register, then output register.
	// That way it pulses on the very edge at which the pins move,
	// so a watcher can treat it as the output update marker.
	always @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			out_strobe_q <= 1'b0;
			tick_out <= 1'b0;
		end
		else
		begin
			out_strobe_q <= latch_q;
			tick_out <= out_strobe_q;
		end
	end

	// ----------------------------------------------------------------
	// Output pins
	// ----------------------------------------------------------------
	// Codes registered again so outputs come straight from flops
	always @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			first_output_channel_out <= `CODE_ZERO;
			second_output_channel_out <= `CODE_ZERO;
			third_output_channel_out <= `CODE_ZERO;
		end
		else
		begin
			first_output_channel_out <= code[0];
			second_output_channel_out <= code[1];
			third_output_channel_out <= code[2];
		end
	end
endmodule // analog_output_scaler

/* sim/analog_output_scaler_properties.sv */
// Port checker for the analog output scaler top.
// Assumes it is bound with the same tick period as the design.
`timescale 1ns/1ns
module analog_output_scaler_chk #(
	parameter int TICK_CYCLES = 16
) (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [31:0] prdata_out,
	input wire pready_out,
	input wire pslverr_out,
	input wire [15:0] first_output_channel_out,
	input wire [15:0] second_output_channel_out,
	input wire [15:0] third_output_channel_out,
	input wire tick_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_setup;
		psel_in && !penable_in ##1 psel_in && penable_in;
	endsequence
	property p_answer; s_setup |=> pready_out; endproperty
	a_answer: assert property (p_answer) else $error("no answer after access");
	property p_pulse; pready_out |=> !pready_out; endproperty
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	property p_cause; pready_out |-> $past(psel_in && penable_in); endproperty
	a_cause: assert property (p_cause) else $error("ready without access");
	property p_err; pslverr_out |-> pready_out; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_idle; !pready_out |-> prdata_out == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer");
	property p_period; tick_out |-> ##TICK_CYCLES tick_out; endproperty
	a_period: assert property (p_period) else $error("tick period wrong");
	property p_gap; tick_out |=> !tick_out [*8]; endproperty
	a_gap: assert property (p_gap) else $error("tick too soon");
	property p_hold;
		$changed({first_output_channel_out, second_output_channel_out,
			third_output_channel_out}) |-> tick_out;
	endproperty
	a_hold: assert property (p_hold) else $error("output moved off tick");
endmodule // analog_output_scaler_chk

bind analog_output_scaler analog_output_scaler_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .first_output_channel_out(first_output_channel_out),
	.second_output_channel_out(second_output_channel_out),
	.third_output_channel_out(third_output_channel_out), .tick_out(tick_out));

/* sim/dac_model.sv */
// Far-side converter model: turns a channel code into millivolts.
// Assumes an ideal linear converter over the selected voltage span.
`timescale 1ns/1ns
module dac_model (
	input wire [15:0] code_in,
	input wire bipolar_in,
	output int mv_out
);
	// Full code is +10 V; bipolar zero code is -10 V
	assign mv_out = bipolar_in ? code_in * 20000 / 65535 - 10000 : code_in * 10000 / 65535;
endmodule // dac_model

/* sim/analog_output_scaler_tb_top.sv */
// Self-checking bench for the analog output scaler.
// Assumes a 16-cycle tick so each update lands within a few dozen cycles.
`timescale 1ns/1ns
module analog_output_scaler_tb_top;
	logic clk = 0, rst_b = 1, psel = 0, pen = 0, pwr = 0, prdy, perr, tick, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] code [3];
	int err_count = 0, check_count = 0, mv, b;
	typedef struct { int ch; int dem; int scl; int ofs; int ctl; logic [15:0] exp; } row_t;
	row_t rows [13] = '{'{0, 10000, 10000, 0, 1, 16'hffff}, '{0, 5000, 20000, 0, 1, 16'hffff},
		'{0, 20000, 5000, -10000, 1, 16'h0}, '{0, 0, 10000, 10000, 1, 16'hffff},
		'{0, 30000, 10000, 0, 1, 16'hffff}, '{0, -10000, 10000, 0, 5, 16'hffff},
		'{0, -10000, 10000, 0, 1, 16'h0}, '{0, 0, 10000, 0, 0, 16'h0},
		'{0, 0, 10000, 0, 3, 16'h3333}, '{0, 10000, 10000, 0, 2, 16'hffff},
		'{2, -10000, 10000, 0, 0, 16'h0}, '{2, 0, 10000, 0, 0, 16'h7fff},
		'{1, 10000, 10000, 0, 0, 16'h0}};
	analog_output_scaler #(.NUM_CHANNELS(3), .TICK_CYCLES(16)) u_dut (
		.core_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(prdy), .pslverr_out(perr), .first_output_channel_out(code[0]),
		.second_output_channel_out(code[1]), .third_output_channel_out(code[2]),
		.tick_out(tick));
	dac_model u_dac (.code_in(code[2]), .bipolar_in(1'b1), .mv_out(mv));
	initial
	begin
		forever #2 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// ------------------------------------------------
	// APB transfer, held until ready is sampled
	// ------------------------------------------------
	task automatic apb(input logic w, input int a, input int d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= 12'(a);
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (n = 0; n < 20 && prdy !== 1'b1; n++)
			@(posedge clk);
		if (n == 20)
		begin
			err_count++;
			print_verdict();
		end
		rd = prdata;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wt(input int k);
		int n;
		repeat (k)
		begin
			@(posedge clk);
			for (n = 0; n < 40 && tick !== 1'b1; n++)
				@(posedge clk);
			if (n == 40)
			begin
				err_count++;
				print_verdict();
			end
		end
	endtask
	initial
	begin
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		chk(code[1], 0);
		wt(1);
		chk(code[1], 32'hffff);
		chk(code[2], 32'h7fff);
		apb(0, 'h020, 0);
		chk(rd, 10000);
		apb(0, 'h004, 0);
		chk(rd, 10000);
		apb(0, 'h0fc, 0);
		chk(er, 1);
		apb(1, 'h000, 40000);
		apb(0, 'h000, 0);
		chk(rd, 30000);
		apb(1, 'h000, -40000);
		apb(0, 'h000, 0);
		chk(rd, -30000);
		$display("reset and register test done");
		foreach (rows[i])
		begin
			b = rows[i].ch * 32;
			apb(1, b, rows[i].dem);
			apb(1, b + 4, rows[i].scl);
			apb(1, b + 8, rows[i].ofs);
			apb(1, b + 12, rows[i].ctl);
			wt(2);
			chk(code[rows[i].ch], rows[i].exp);
			$display("row %0d done", i);
		end
		apb(0, 'h100, 0);
		chk(rd[2:0], 3'h2);
		apb(1, 'h040, -10000);
		wt(2);
		chk(mv, -10000);
		apb(1, 'h040, 10000);
		wt(2);
		chk(mv, 10000);
		$display("converter test done");
		print_verdict();
	end
endmodule // analog_output_scaler_tb_top
